// *** design/cap_pkg.sv ***
`include "cap_regs.svh"
package cap_pkg;
    typedef enum logic [1:0] {
        cap_cyc_8  = 2'b00,
        cap_cyc_9  = 2'b01,
        cap_cyc_10 = 2'b10,
        cap_cyc_11 = 2'b11
    } cap_cycle_t;

    typedef enum logic [1:0] {
        cap_ch_idle  = 2'b00,
        cap_ch_short = 2'b01,
        cap_ch_wide  = 2'b10,
        cap_ch_zero  = 2'b11
    } cap_chan_t;

    function automatic logic [15:0] cap_cycle_mask(input cap_cycle_t sel);
        unique case (sel)
            cap_cyc_8:  return `CAP_MASK_8;
            cap_cyc_9:  return `CAP_MASK_9;
            cap_cyc_10: return `CAP_MASK_10;
            cap_cyc_11: return `CAP_MASK_11;
        endcase
    endfunction

    function automatic cap_chan_t cap_chan_mode(input logic [7:0] m);
        if (!m[`CAP_MODE_PWM])
            return cap_ch_idle;
        else if (!m[`CAP_MODE_ECOM])
            return cap_ch_zero;
        else if (m[`CAP_MODE_WIDE])
            return cap_ch_wide;
        else
            return cap_ch_short;
    endfunction
endpackage

// *** design/cap_pwm_array.sv ***
`timescale 1ns/1ps
`include "cap_regs.svh"
module cap_pwm_array (
    // clock and reset
    input  logic        core_clk,
    input  logic        rst,
    // special function register bus
    input  logic [7:0]  sfr_addr,
    input  logic [7:0]  sfr_wdata,
    input  logic        sfr_wr,
    input  logic        sfr_rd,
    output logic [7:0]  sfr_rdata,
    // counter timebase, one-cycle tick
    input  logic        timebase_tick,
    // module pins and interrupt
    output logic [2:0]  module_output_pin,
    output logic        counter_array_irq
);
    import cap_pkg::*;

    localparam int NCH = `CAP_NUM_CH;

    function automatic logic [7:0] mode_addr(input int n);
        return 8'(`CAP_ADDR_MODE0 + n);
    endfunction

    function automatic logic [7:0] low_addr(input int n);
        return 8'(`CAP_ADDR_CMP0 + `CAP_CMP_STRIDE * n);
    endfunction

    function automatic logic [7:0] high_addr(input int n);
        return 8'(`CAP_ADDR_CMP0 + `CAP_CMP_STRIDE * n + 1);
    endfunction

    logic [15:0] cnt_reg;
    logic [15:0] cnt_incr;
    logic [7:0]  ctrl_reg;
    logic [7:0]  ctrl_next;
    logic [7:0]  cfg_reg;
    logic [7:0]  cfg_next;
    logic [7:0]  md_reg;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;
    logic        irq_reg;
    logic        irq_next;

    logic        run;
    logic        bank_sel;
    logic        cnt_wr;
    logic        cnt_adv;
    logic        cyc_wrap;
    logic        full_wrap;
    logic        short8;
    cap_cycle_t  cyc_sel;
    logic [15:0] cyc_mask;

    logic [7:0]     ch_mode   [NCH];
    logic [15:0]    ch_cmp    [NCH];
    logic [15:0]    ch_reload [NCH];
    logic [NCH-1:0] ch_match;
    logic [NCH-1:0] ch_pin;
    logic [NCH-1:0] ch_eccf;

    assign run      = ctrl_reg[`CAP_CTRL_CR];
    assign bank_sel = cfg_reg[`CAP_CFG_RELOAD_BANK_SELECT];
    assign cyc_sel  = cap_cycle_t'(cfg_reg[1:0]);
    assign cyc_mask = cap_cycle_mask(cyc_sel);
    assign short8   = (cyc_sel == cap_cyc_8);
    assign cnt_wr   = sfr_wr && ((sfr_addr == `CAP_ADDR_CNT_LO)
                              || (sfr_addr == `CAP_ADDR_CNT_HI));

    // a software write to the counter takes the tick's place
    assign cnt_adv  = timebase_tick && run && !cnt_wr;
    assign cnt_incr = cnt_reg + 16'h0001;

    // low N bits roll over to zero: 256/512/1024/2048 ticks apart
    assign cyc_wrap  = cnt_adv
                    && ((cnt_incr & cyc_mask) == `CAP_RESET_WORD);
    assign full_wrap = cnt_adv && (cnt_incr == `CAP_RESET_WORD);

    always_ff @(posedge core_clk)
    begin
        if (rst)
            cnt_reg <= `CAP_RESET_WORD;
        else if (sfr_wr && sfr_addr == `CAP_ADDR_CNT_LO)
            cnt_reg[7:0] <= sfr_wdata;
        else if (sfr_wr && sfr_addr == `CAP_ADDR_CNT_HI)
            cnt_reg[15:8] <= sfr_wdata;
        else if (cnt_adv)
            cnt_reg <= cnt_incr;
    end

    // three modules see the same count in the same cycle
    generate
        for (genvar i = 0; i < NCH; i++)
        begin : g_ch
            cap_pwm_channel u_ch (
                .core_clk   (core_clk),
                .rst        (rst),
                .cnt_next   (cnt_incr),
                .cnt_adv    (cnt_adv),
                .cyc_wrap   (cyc_wrap),
                .full_wrap  (full_wrap),
                .cyc_mask   (cyc_mask),
                .short8     (short8),
                .wdata      (sfr_wdata),
                .bank_sel   (bank_sel),
                .wr_mode    (sfr_wr && sfr_addr == mode_addr(i)),
                .wr_low     (sfr_wr && sfr_addr == low_addr(i)),
                .wr_high    (sfr_wr && sfr_addr == high_addr(i)),
                .mode_reg   (ch_mode[i]),
                .cmp_reg    (ch_cmp[i]),
                .reload_reg (ch_reload[i]),
                .match_evt  (ch_match[i]),
                .pin_reg    (ch_pin[i])
            );
            assign ch_eccf[i] = ch_mode[i][`CAP_MODE_ECCF];
        end
    endgenerate

    // hardware sets win over a software clear in the same cycle
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (sfr_wr && sfr_addr == `CAP_ADDR_CTRL)
            ctrl_next = sfr_wdata & `CAP_CTRL_WMASK;
        if (full_wrap)
            ctrl_next[`CAP_CTRL_CF] = 1'b1;
        ctrl_next[NCH-1:0] = ctrl_next[NCH-1:0] | ch_match;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            ctrl_reg <= `CAP_RESET_BYTE;
        else
            ctrl_reg <= ctrl_next;
    end

    always_comb
    begin
        cfg_next = cfg_reg;
        if (sfr_wr && sfr_addr == `CAP_ADDR_CFG)
            cfg_next = sfr_wdata & `CAP_CFG_WMASK;
        if (cyc_wrap)
            cfg_next[`CAP_CFG_CYCLE_OVERFLOW_FLAG] = 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            cfg_reg <= `CAP_RESET_BYTE;
        else
            cfg_reg <= cfg_next;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            md_reg <= `CAP_RESET_BYTE;
        else if (sfr_wr && sfr_addr == `CAP_ADDR_MD)
            md_reg <= sfr_wdata & `CAP_MD_WMASK;
    end

    // interrupt request from flags masked by their enables
    always_comb
    begin
        irq_next = (ctrl_reg[`CAP_CTRL_CF] && md_reg[`CAP_MD_ECF])
                || (cfg_reg[`CAP_CFG_CYCLE_OVERFLOW_FLAG]
                    && cfg_reg[`CAP_CFG_CYCLE_OVERFLOW_IRQ_ENABLE])
                || (|(ctrl_reg[NCH-1:0] & ch_eccf));
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            irq_reg <= 1'b0;
        else
            irq_reg <= irq_next;
    end

    // read mux; compare addresses follow the bank select
    always_comb
    begin
        rdata_next = `CAP_RESET_BYTE;
        case (sfr_addr)
            `CAP_ADDR_CTRL:   rdata_next = ctrl_reg;
            `CAP_ADDR_CFG:    rdata_next = cfg_reg;
            `CAP_ADDR_MD:     rdata_next = md_reg;
            `CAP_ADDR_CNT_LO: rdata_next = cnt_reg[7:0];
            `CAP_ADDR_CNT_HI: rdata_next = cnt_reg[15:8];
            default:          rdata_next = `CAP_RESET_BYTE;
        endcase
        for (int i = 0; i < NCH; i++)
        begin
            if (sfr_addr == mode_addr(i))
                rdata_next = ch_mode[i];
            if (sfr_addr == low_addr(i))
                rdata_next = bank_sel ? ch_reload[i][7:0]
                                      : ch_cmp[i][7:0];
            if (sfr_addr == high_addr(i))
                rdata_next = bank_sel ? ch_reload[i][15:8]
                                      : ch_cmp[i][15:8];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            rdata_reg <= `CAP_RESET_BYTE;
        else if (sfr_rd)
            rdata_reg <= rdata_next;
    end

    assign sfr_rdata         = rdata_reg;
    assign module_output_pin = ch_pin;
    assign counter_array_irq = irq_reg;

    count_step_a: assert property (
        @(posedge core_clk) disable iff (rst)
        cnt_adv |=> cnt_reg == $past(cnt_reg) + 16'h0001)
        else $error("counter did not step by one");
    count_hold_a: assert property (
        @(posedge core_clk) disable iff (rst)
        !run && !cnt_wr |=> $stable(cnt_reg))
        else $error("stopped counter moved");
    wrap_flag_a: assert property (
        @(posedge core_clk) disable iff (rst)
        cnt_adv && cnt_reg == `CAP_MASK_16 |=> ctrl_reg[`CAP_CTRL_CF])
        else $error("wrap flag not set");
    wrap_sticky_a: assert property (
        @(posedge core_clk) disable iff (rst)
        ctrl_reg[`CAP_CTRL_CF] && !(sfr_wr && sfr_addr == `CAP_ADDR_CTRL)
        |=> ctrl_reg[`CAP_CTRL_CF])
        else $error("wrap flag cleared by hardware");
    wrap_quiet_a: assert property (
        @(posedge core_clk) disable iff (rst)
        !ctrl_reg[`CAP_CTRL_CF] && !full_wrap
        && !(sfr_wr && sfr_addr == `CAP_ADDR_CTRL) |=> !ctrl_reg[`CAP_CTRL_CF])
        else $error("wrap flag set without a wrap");
    cycle_flag_a: assert property (
        @(posedge core_clk) disable iff (rst)
        cnt_adv && short8 && cnt_reg[7:0] == 8'hff
        |=> cfg_reg[`CAP_CFG_CYCLE_OVERFLOW_FLAG])
        else $error("cycle flag not set");
    cycle_early_a: assert property (
        @(posedge core_clk) disable iff (rst)
        cnt_adv && short8 && cnt_reg[7:0] != 8'hff
        && !cfg_reg[`CAP_CFG_CYCLE_OVERFLOW_FLAG] && !(sfr_wr && sfr_addr == `CAP_ADDR_CFG)
        |=> !cfg_reg[`CAP_CFG_CYCLE_OVERFLOW_FLAG])
        else $error("cycle flag set early");
    cycle_nine_a: assert property (
        @(posedge core_clk) disable iff (rst)
        cnt_adv && cyc_sel == cap_cyc_9 && cnt_reg[8:0] == 9'h1ff
        |=> cfg_reg[`CAP_CFG_CYCLE_OVERFLOW_FLAG])
        else $error("9-bit cycle flag not set");
    cycle_ten_a: assert property (
        @(posedge core_clk) disable iff (rst)
        cnt_adv && cyc_sel == cap_cyc_10 && cnt_reg[9:0] == 10'h3ff
        |=> cfg_reg[`CAP_CFG_CYCLE_OVERFLOW_FLAG])
        else $error("10-bit cycle flag not set");
    cycle_eleven_a: assert property (
        @(posedge core_clk) disable iff (rst)
        cnt_adv && cyc_sel == cap_cyc_11 && cnt_reg[10:0] == 11'h7ff
        |=> cfg_reg[`CAP_CFG_CYCLE_OVERFLOW_FLAG])
        else $error("11-bit cycle flag not set");
    cycle_overflow_flag_sticky_a: assert property (
        @(posedge core_clk) disable iff (rst)
        cfg_reg[`CAP_CFG_CYCLE_OVERFLOW_FLAG] && !(sfr_wr && sfr_addr == `CAP_ADDR_CFG)
        |=> cfg_reg[`CAP_CFG_CYCLE_OVERFLOW_FLAG])
        else $error("cycle flag cleared by hardware");
    event_flag_a: assert property (
        @(posedge core_clk) disable iff (rst)
        ch_match != '0
        |=> (ctrl_reg[NCH-1:0] & $past(ch_match)) == $past(ch_match))
        else $error("event flag lost");
    ccf_sticky_a: assert property (
        @(posedge core_clk) disable iff (rst)
        !(sfr_wr && sfr_addr == `CAP_ADDR_CTRL) |=> (ctrl_reg[NCH-1:0]
        & $past(ctrl_reg[NCH-1:0])) == $past(ctrl_reg[NCH-1:0]))
        else $error("event flag cleared by hardware");
    ccf_irq_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (ctrl_reg[NCH-1:0] & ch_eccf) != '0 |=> counter_array_irq)
        else $error("event flag did not request irq");
    wrap_irq_a: assert property (
        @(posedge core_clk) disable iff (rst)
        ctrl_reg[`CAP_CTRL_CF] && md_reg[`CAP_MD_ECF] |=> counter_array_irq)
        else $error("wrap flag did not request irq");
    cycle_irq_a: assert property (
        @(posedge core_clk) disable iff (rst)
        cfg_reg[`CAP_CFG_CYCLE_OVERFLOW_FLAG] && cfg_reg[`CAP_CFG_CYCLE_OVERFLOW_IRQ_ENABLE]
        |=> counter_array_irq)
        else $error("cycle overflow did not request irq");
    cycle_masked_a: assert property (
        @(posedge core_clk) disable iff (rst)
        !cfg_reg[`CAP_CFG_CYCLE_OVERFLOW_IRQ_ENABLE] && !ctrl_reg[`CAP_CTRL_CF]
        && ctrl_reg[NCH-1:0] == '0 |=> !counter_array_irq)
        else $error("masked cycle flag raised irq");
    irq_quiet_a: assert property (
        @(posedge core_clk) disable iff (rst)
        !ctrl_reg[`CAP_CTRL_CF] && !cfg_reg[`CAP_CFG_CYCLE_OVERFLOW_FLAG]
        && ctrl_reg[NCH-1:0] == '0 |=> !counter_array_irq)
        else $error("irq without a flag");
    read_reload_a: assert property (
        @(posedge core_clk) disable iff (rst)
        sfr_rd && bank_sel && sfr_addr == low_addr(0)
        |=> sfr_rdata == $past(ch_reload[0][7:0]))
        else $error("reload bank not read");
    read_compare_a: assert property (
        @(posedge core_clk) disable iff (rst)
        sfr_rd && !bank_sel && sfr_addr == high_addr(0)
        |=> sfr_rdata == $past(ch_cmp[0][15:8]))
        else $error("compare bank not read");
    rdata_hold_a: assert property (
        @(posedge core_clk) disable iff (rst)
        !sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved without a read");
    pin_follows_a: assert property (
        @(posedge core_clk) disable iff (rst)
        !run ##1 !run |-> $stable(module_output_pin)
        || module_output_pin == '0)
        else $error("pin moved while stopped");
endmodule // cap_pwm_array

// *** design/cap_pwm_channel.sv ***
`timescale 1ns/1ps
`include "cap_regs.svh"
module cap_pwm_channel (
    // clock and reset
    input  logic        core_clk,
    input  logic        rst,
    // shared counter view
    input  logic [15:0] cnt_next,
    input  logic        cnt_adv,
    input  logic        cyc_wrap,
    input  logic        full_wrap,
    input  logic [15:0] cyc_mask,
    input  logic        short8,
    // register writes
    input  logic [7:0]  wdata,
    input  logic        bank_sel,
    input  logic        wr_mode,
    input  logic        wr_low,
    input  logic        wr_high,
    // state
    output logic [7:0]  mode_reg,
    output logic [15:0] cmp_reg,
    output logic [15:0] reload_reg,
    output logic        match_evt,
    output logic        pin_reg
);
    import cap_pkg::*;

    cap_chan_t   mode;
    logic        wide;
    logic        active;
    logic        wrap;
    logic        hit;
    logic [15:0] mask;
    logic [15:0] fresh;
    logic [15:0] ref_val;

    assign mode   = cap_chan_mode(mode_reg);
    assign wide   = (mode == cap_ch_wide);
    assign active = wide || (mode == cap_ch_short);
    assign mask   = wide ? `CAP_MASK_16 : cyc_mask;
    assign wrap   = active && (wide ? full_wrap : cyc_wrap);
    // 8-bit mode reloads low from high; 9- to 11-bit modes take the reload bank
    assign fresh  = short8 ? {cmp_reg[15:8], cmp_reg[15:8]} : reload_reg;
    // compare against the value reloaded at this very wrap
    assign ref_val = (wrap && !wide) ? fresh : cmp_reg;
    assign hit = active && cnt_adv
              && ((cnt_next & mask) == (ref_val & mask));
    assign match_evt = hit && mode_reg[`CAP_MODE_MAT];

    always_ff @(posedge core_clk)
    begin
        if (rst)
            pin_reg <= 1'b0;
        else if (!active)
            pin_reg <= 1'b0;
        else if (hit)
            pin_reg <= 1'b1;
        else if (wrap)
            pin_reg <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            mode_reg <= `CAP_RESET_BYTE;
        else if (wr_mode)
            mode_reg <= wdata & `CAP_MODE_WMASK;
        else if (wr_low && !bank_sel)
            mode_reg[`CAP_MODE_ECOM] <= 1'b0;
        else if (wr_high && !bank_sel)
            mode_reg[`CAP_MODE_ECOM] <= 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            cmp_reg <= `CAP_RESET_WORD;
        else
        begin
            if (wrap && !wide)
                cmp_reg <= fresh;
            if (wr_low && !bank_sel)
                cmp_reg[7:0] <= wdata;
            if (wr_high && !bank_sel)
                cmp_reg[15:8] <= wdata;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            reload_reg <= `CAP_RESET_WORD;
        else if (wr_low && bank_sel)
            reload_reg[7:0] <= wdata;
        else if (wr_high && bank_sel)
            reload_reg[15:8] <= wdata;
    end

    rise_on_match_a: assert property (
        @(posedge core_clk) disable iff (rst)
        hit |=> pin_reg)
        else $error("pin did not rise on match");
    fall_on_wrap_a: assert property (
        @(posedge core_clk) disable iff (rst)
        wrap && !hit |=> !pin_reg)
        else $error("pin did not fall");
    low_when_off_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (mode == cap_ch_zero) |=> !pin_reg)
        else $error("pin high");
    ecom_low_write_a: assert property (
        @(posedge core_clk) disable iff (rst)
        wr_low && !bank_sel && !wr_mode |=> !mode_reg[`CAP_MODE_ECOM])
        else $error("low write left comparator on");
    reload_eight_a: assert property (
        @(posedge core_clk) disable iff (rst)
        wrap && short8 && !wide && !wr_low && !wr_high
        |=> cmp_reg[7:0] == $past(cmp_reg[15:8]))
        else $error("8-bit reload missed");
endmodule // cap_pwm_channel

// *** design/cap_regs.svh ***
`ifndef CAP_REGS_SVH
`define CAP_REGS_SVH
`define CAP_NUM_CH      3
`define CAP_ADDR_CTRL   8'hd8
`define CAP_ADDR_CFG    8'ha1
`define CAP_ADDR_MD     8'hed
`define CAP_ADDR_CNT_LO 8'hf9
`define CAP_ADDR_CNT_HI 8'hfa
`define CAP_ADDR_MODE0  8'hda
`define CAP_ADDR_CMP0   8'he0
`define CAP_CMP_STRIDE  2
`define CAP_CTRL_CF     7
`define CAP_CTRL_CR     6
`define CAP_CFG_RELOAD_BANK_SELECT   7
`define CAP_CFG_CYCLE_OVERFLOW_IRQ_ENABLE    6
`define CAP_CFG_CYCLE_OVERFLOW_FLAG    5
`define CAP_MD_ECF      0
`define CAP_MODE_WIDE   7
`define CAP_MODE_ECOM   6
`define CAP_MODE_MAT    3
`define CAP_MODE_PWM    1
`define CAP_MODE_ECCF   0
`define CAP_CTRL_WMASK  8'hc7
`define CAP_CFG_WMASK   8'he3
`define CAP_MD_WMASK    8'h01
`define CAP_MODE_WMASK  8'hcb
`define CAP_RESET_BYTE  8'h00
`define CAP_RESET_WORD  16'h0000
`define CAP_MASK_8      16'h00ff
`define CAP_MASK_9      16'h01ff
`define CAP_MASK_10     16'h03ff
`define CAP_MASK_11     16'h07ff
`define CAP_MASK_16     16'hffff
`endif

// *** testbench/cap_load_model.sv ***
`timescale 1ns/1ps
module cap_load_model (
    // clock and reset
    input  logic        core_clk,
    input  logic        rst,
    // driven pins
    input  logic [2:0]  load_pin,
    // measured waveform per pin
    output logic [31:0] high_len [3],
    output logic [31:0] period_len [3],
    output logic [31:0] fall_cnt [3]
);
    logic [31:0] high_run_reg [3];
    logic [31:0] since_fall_reg [3];
    logic [2:0]  pin_prev_reg;

    // high time and period, both latched at each falling edge
    always_ff @(posedge core_clk)
    begin
        pin_prev_reg <= rst ? 3'h0 : load_pin;
        for (int i = 0; i < 3; i++)
        begin
            if (rst)
            begin
                high_len[i]       <= 32'h0;
                period_len[i]     <= 32'h0;
                fall_cnt[i]       <= 32'h0;
                high_run_reg[i]   <= 32'h0;
                since_fall_reg[i] <= 32'h0;
            end
            else if (pin_prev_reg[i] && !load_pin[i])
            begin
                high_len[i]       <= high_run_reg[i];
                period_len[i]     <= since_fall_reg[i];
                fall_cnt[i]       <= fall_cnt[i] + 32'h1;
                high_run_reg[i]   <= 32'h0;
                since_fall_reg[i] <= 32'h1;
            end
            else
            begin
                high_run_reg[i]   <= high_run_reg[i] + {31'h0, load_pin[i]};
                since_fall_reg[i] <= since_fall_reg[i] + 32'h1;
            end
        end
    end
endmodule // cap_load_model

// *** testbench/counter_array_pwm_modes_tb.sv ***
`timescale 1ns/1ps
module counter_array_pwm_modes_tb;
    logic        core_clk;
    logic        rst;
    logic [7:0]  sfr_addr;
    logic [7:0]  sfr_wdata;
    logic        sfr_wr;
    logic        sfr_rd;
    logic [7:0]  sfr_rdata;
    logic        timebase_tick;
    logic [2:0]  module_output_pin;
    logic        counter_array_irq;
    logic [31:0] high_len [3];
    logic [31:0] period_len [3];
    logic [31:0] fall_cnt [3];
    logic [7:0]  rd_val;
    int          err_count;
    int          comparisons;

    cap_pwm_array dut (
        .core_clk          (core_clk),
        .rst               (rst),
        .sfr_addr          (sfr_addr),
        .sfr_wdata         (sfr_wdata),
        .sfr_wr            (sfr_wr),
        .sfr_rd            (sfr_rd),
        .sfr_rdata         (sfr_rdata),
        .timebase_tick     (timebase_tick),
        .module_output_pin (module_output_pin),
        .counter_array_irq (counter_array_irq)
    );

    cap_load_model load (
        .core_clk   (core_clk),
        .rst        (rst),
        .load_pin   (module_output_pin),
        .high_len   (high_len),
        .period_len (period_len),
        .fall_cnt   (fall_cnt)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic results();
        $display("counts: %0d compares, %0d mismatches", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(posedge core_clk);
        #1;
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        #1;
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(posedge core_clk);
        #1;
        sfr_rd = 1'b0;
        rd_val = sfr_rdata;
    endtask

    // bounded wait for n more falling edges on pin 0
    task automatic wait_falls(input int n, input int limit);
        int base;
        int k;
        base = fall_cnt[0];
        k = 0;
        while (fall_cnt[0] < base + n && k < limit)
        begin
            @(posedge core_clk);
            k++;
        end
        #1;
        if (k >= limit)
        begin
            err_count++;
            $display("[ERR] t=%0t wait ran out %h %h", $time, k, limit);
            results();
        end
    endtask

    task automatic test_reset();
        logic [7:0] addrs [7];
        addrs = '{8'hd8, 8'ha1, 8'hed, 8'hda, 8'he0, 8'hf9, 8'h00};
        foreach (addrs[i])
        begin
            rd(addrs[i]);
            chk8(rd_val, 8'h00);
        end
        wr(8'hed, 8'hff);
        rd(8'hed);
        chk8(rd_val, 8'h01);
        wr(8'hed, 8'h00);
        wr(8'hd8, 8'h38);
        rd(8'hd8);
        chk8(rd_val, 8'h00);
        $display("test reset done");
    endtask

    task automatic test_8bit();
        wr(8'ha1, 8'h00);
        wr(8'hda, 8'h4a);
        wr(8'he0, 8'h00);
        rd(8'hda);
        chk8(rd_val, 8'h0a);
        wr(8'he1, 8'h40);
        rd(8'hda);
        chk8(rd_val, 8'h4a);
        wr(8'hdb, 8'h42);
        wr(8'he2, 8'h00);
        wr(8'he3, 8'h00);
        wr(8'hdc, 8'h42);
        wr(8'he4, 8'h80);
        rd(8'hdc);
        chk8(rd_val, 8'h02);
        wr(8'hd8, 8'h40);
        wait_falls(2, 1000);
        chk32(high_len[0], 32'h0000_00c0);
        chk32(period_len[0], 32'h0000_0100);
        chk8({7'h0, module_output_pin[1]}, 8'h01);
        chk8({7'h0, module_output_pin[2]}, 8'h00);
        chk8({7'h0, counter_array_irq}, 8'h00);
        rd(8'hd8);
        chk8(rd_val, 8'h41);
        rd(8'ha1);
        chk8(rd_val, 8'h20);
        rd(8'he0);
        chk8(rd_val, 8'h40);
        $display("test 8-bit done");
    endtask

    task automatic test_nbit();
        logic [15:0] val;
        logic [7:0]  sel;
        int          per;
        for (int n = 9; n <= 11; n++)
        begin
            per = 1 << n;
            val = 16'(per / 4 + n);
            sel = 8'(n - 8);
            wr(8'hd8, 8'h00);
            wr(8'hf9, 8'h00);
            wr(8'hfa, 8'h00);
            wr(8'ha1, 8'h80 | sel);
            wr(8'he0, val[7:0]);
            wr(8'he1, val[15:8]);
            rd(8'he0);
            chk8(rd_val, val[7:0]);
            wr(8'ha1, sel);
            rd(8'hda);
            chk8(rd_val, 8'h4a);
            wr(8'hd8, 8'h40);
            wait_falls(2, 3 * per);
            chk32(high_len[0], 32'(per) - 32'(val));
            chk32(period_len[0], 32'(per));
            rd(8'ha1);
            chk8(rd_val, 8'h20 | sel);
            chk8({7'h0, counter_array_irq}, 8'h00);
            rd(8'hd8);
            chk8(rd_val, 8'h41);
            wr(8'hd8, 8'h00);
            wr(8'ha1, 8'h60 | sel);
            repeat (2) @(posedge core_clk);
            #1;
            chk8({7'h0, counter_array_irq}, 8'h01);
            wr(8'ha1, sel);
        end
        $display("test 9/10/11-bit done");
    endtask

    task automatic test_wide();
        logic [7:0] held;
        wr(8'hd8, 8'h00);
        wr(8'ha1, 8'h00);
        wr(8'hdb, 8'h00);
        wr(8'hdc, 8'h00);
        wr(8'hda, 8'h00);
        wr(8'hda, 8'hca);
        wr(8'he0, 8'hf0);
        wr(8'he1, 8'hff);
        rd(8'hda);
        chk8(rd_val, 8'hca);
        chk8({6'h0, module_output_pin[2:1]}, 8'h00);
        wr(8'hf9, 8'he0);
        wr(8'hfa, 8'hff);
        wr(8'hed, 8'h01);
        repeat (4) @(posedge core_clk);
        rd(8'hf9);
        chk8(rd_val, 8'he0);
        wr(8'hd8, 8'h40);
        wait_falls(1, 100);
        chk32(high_len[0], 32'h0000_0010);
        rd(8'hd8);
        chk8(rd_val, 8'hc1);
        chk8({7'h0, counter_array_irq}, 8'h01);
        wr(8'hd8, 8'h40);
        rd(8'hd8);
        chk8(rd_val, 8'h40);
        chk8({7'h0, counter_array_irq}, 8'h00);
        wr(8'hda, 8'hcb);
        wr(8'hd8, 8'h41);
        @(posedge core_clk);
        #1;
        chk8({7'h0, counter_array_irq}, 8'h01);
        wr(8'hd8, 8'h40);
        timebase_tick = 1'b0;
        rd(8'hf9);
        held = rd_val;
        rd(8'hf9);
        chk8(rd_val, held);
        timebase_tick = 1'b1;
        $display("test 16-bit done");
    endtask

    initial
    begin
        rst           = 1'b1;
        sfr_addr      = 8'h00;
        sfr_wdata     = 8'h00;
        sfr_wr        = 1'b0;
        sfr_rd        = 1'b0;
        timebase_tick = 1'b1;
        err_count     = 0;
        comparisons   = 0;
        repeat (5) @(posedge core_clk);
        #1;
        rst = 1'b0;
        test_reset();
        test_8bit();
        test_nbit();
        test_wide();
        results();
    end
endmodule // counter_array_pwm_modes_tb
